// *** pkg/eiu_pkg.sv ***
// Package of constants and types for the external interrupt unit.
package eiu_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [15:0] IDX_PORT7_DATA = 16'hffda;
  localparam logic [15:0] IDX_PORT7_DIR  = 16'hffea;
  localparam logic [15:0] IDX_PORT_MODE1 = 16'hffe0;
  localparam logic [15:0] IDX_PORT_MODE5 = 16'hffe4;
  localparam logic [15:0] IDX_CPU_MASK   = 16'hfff0;
  localparam logic [15:0] IDX_EDGE_SEL   = 16'hfff2;
  localparam logic [15:0] IDX_WAKE_EDGE  = 16'hfff3;
  localparam logic [15:0] IDX_ENABLE     = 16'hfff4;
  localparam logic [15:0] IDX_FLAGS      = 16'hfff6;
  localparam logic [15:0] IDX_WAKE_FLAGS = 16'hfff8;

  // Field positions.
  localparam int unsigned LED_BIT       = 4;
  localparam int unsigned NMI_EDGE_BIT  = 7;
  localparam int unsigned WAKE_EN_BIT   = 5;
  localparam int unsigned MODE1_IRQ_LO  = 4;
  localparam int unsigned MASK_BIT      = 7;
  localparam int unsigned PIN_NMI       = 0;
  localparam int unsigned PIN_IRQ_LO    = 1;
  localparam int unsigned PIN_WAKE_LO   = 5;
  localparam int unsigned NUM_PINS      = 11;

  // Values after reset.
  localparam logic [7:0]  RST_REG   = 8'h00;
  localparam logic        RST_MASK  = 1'b1;
  localparam logic [1:0]  RST_SYNC  = 2'h0;

  // Source codes; lower code wins arbitration.
  typedef logic [2:0] eiu_src_t;
  localparam eiu_src_t SRC_NMI  = 3'h0;
  localparam eiu_src_t SRC_IRQ0 = 3'h1;
  localparam eiu_src_t SRC_WAKE = 3'h5;

  // Vector table base; arbitrary value, two bytes per entry.
  localparam logic [15:0] VEC_BASE = 16'h0010;

  typedef struct packed {
    logic     valid;
    eiu_src_t src;
  } eiu_req_t;

  typedef struct packed {
    logic        we;
    logic [15:0] data;
  } eiu_stack_t;

  typedef struct packed {
    logic        load;
    logic [15:0] addr;
  } eiu_vec_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_END,
    ST_PUSH_CCR,
    ST_LOAD_VEC
  } eiu_seq_st_t;

  function automatic logic [15:0] vec_addr(input eiu_src_t src);
    vec_addr = VEC_BASE + {12'h000, src, 1'b0};
  endfunction

  function automatic logic reg_hit(input logic [17:0] addr, input logic [15:0] idx);
    reg_hit = (addr[17:2] == idx) && (addr[1:0] == 2'h0);
  endfunction

endpackage : eiu_pkg

// *** design/eiu_edge.sv ***
// Edge detector for every interrupt pin, with a per-pin polarity choice.
module eiu_edge
  import eiu_pkg::*;
(
  // Clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                rst_b_i,
  // Pins and polarity
  input  wire logic [NUM_PINS-1:0] pins_i,
  input  wire logic [NUM_PINS-1:0] rise_sel_i,
  // One-cycle edge pulses
  output logic      [NUM_PINS-1:0] pulse_o
);

  typedef struct packed {
    logic                armed;
    logic [NUM_PINS-1:0] prev;
    logic [NUM_PINS-1:0] pulse;
  } eiu_edge_st_t;

  eiu_edge_st_t st_q;
  eiu_edge_st_t st_d;

  // The first sample after reset only arms the detector, so a pin
  // already low or high at reset does not look like an edge.
  always_comb
  begin
    st_d       = st_q;
    st_d.armed = 1'b1;
    st_d.prev  = pins_i;
    st_d.pulse = '0;
    if (st_q.armed)
    begin
      st_d.pulse = (rise_sel_i & ~st_q.prev & pins_i) | (~rise_sel_i & st_q.prev & ~pins_i);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign pulse_o = st_q.pulse;

endmodule // eiu_edge

// *** design/eiu_accept.sv ***
// Acceptance sequence: wait for instruction end, stack PC and CCR, load vector.
module eiu_accept
  import eiu_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  // Forwarded request
  input  wire eiu_req_t    req_i,
  input  wire logic [7:0]  ccr_i,
  output logic             busy_o,
  output logic             take_o,
  output eiu_src_t         take_src_o,
  // CPU side
  input  wire logic        insn_end_i,
  input  wire logic [15:0] next_pc_i,
  output eiu_stack_t       stack_o,
  output eiu_vec_t         vector_o
);

  typedef struct packed {
    eiu_seq_st_t st;
    eiu_src_t    src;
    logic [7:0]  ccr;
    logic        take;
    eiu_stack_t  stack;
    eiu_vec_t    vec;
  } eiu_acc_st_t;

  eiu_acc_st_t st_q;
  eiu_acc_st_t st_d;

  always_comb
  begin
    st_d          = st_q;
    st_d.take     = 1'b0;
    st_d.stack.we = 1'b0;
    st_d.vec.load = 1'b0;
    case (st_q.st)
      ST_IDLE:
      begin
        // The CCR is captured before the mask bit is raised.
        if (req_i.valid)
        begin
          st_d.src  = req_i.src;
          st_d.ccr  = ccr_i;
          st_d.take = 1'b1;
          st_d.st   = ST_WAIT_END;
        end
      end
      ST_WAIT_END:
      begin
        if (insn_end_i)
        begin
          st_d.stack = '{we: 1'b1, data: next_pc_i};
          st_d.st    = ST_PUSH_CCR;
        end
      end
      ST_PUSH_CCR:
      begin
        st_d.stack = '{we: 1'b1, data: {8'h00, st_q.ccr}};
        st_d.st    = ST_LOAD_VEC;
      end
      default:
      begin
        st_d.vec = '{load: 1'b1, addr: vec_addr(st_q.src)};
        st_d.st  = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_q <= '{st: ST_IDLE, default: '0};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign busy_o     = (st_q.st != ST_IDLE);
  assign take_o     = st_q.take;
  assign take_src_o = st_q.src;
  assign stack_o    = st_q.stack;
  assign vector_o   = st_q.vec;

endmodule // eiu_accept

// *** design/eiu_top.sv ***
// External interrupt unit: pin edges, flags, enables, arbitration, CPU acceptance, LED port bit.
//
// Operation
// - Six sources: non-maskable pin, four general request pins, wakeup group.
// - Non-maskable pin edge chosen by its edge select bit.
// - Non-maskable request has top priority and ignores the mask bit.
// - Each general pin detects its own selected edge.
// - General pin is an interrupt input only when its port mode bit is 1.
// - Selected edge on a configured general pin sets its flag and requests.
// - Enable bit at 0 disables that general pin's interrupt.
// - Each wakeup pin detects its own selected edge.
// - Wakeup pin is an interrupt input only when its port mode bit is 1.
// - Selected edge on a configured wakeup pin sets its flag and requests.
// - Wakeup group enable at 0 disables all wakeup interrupts.
// - Mask bit at 1 masks all maskable requests.
// - Only the highest priority request goes forward; others stay pending.
// - Maskable request is accepted only with mask 0, else held pending.
// - After acceptance finish the instruction, then stack PC and CCR.
// - Acceptance sets the mask bit to 1.
// - Vector address of the source is loaded into PC.
// - Pin 0 edge select is bit 0 at fff2: 0 falling, 1 rising.
// - Pin 0 request flag is bit 0 at fff6: 1 pending.
// - Pin 0 enable is bit 0 at fff4: 1 allows requests.
// - LED pin drives port data bit 4 when direction bit 4 is 1.
//
// Our own choice: the Avalon-MM register port.
module eiu_top
  import eiu_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  // Interrupt pins
  input  wire logic        nmi_pin_i,
  input  wire logic [3:0]  irq_pins_i,
  input  wire logic [5:0]  wakeup_pins_i,
  // Avalon-MM slave
  input  wire logic [17:0] avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // CPU core
  input  wire logic        cpu_insn_end_i,
  input  wire logic [15:0] cpu_next_pc_i,
  input  wire logic [7:0]  cpu_ccr_i,
  output eiu_req_t         cpu_req_o,
  output logic             cpu_mask_o,
  output eiu_stack_t       cpu_stack_o,
  output eiu_vec_t         cpu_vector_o,
  // LED port pin
  output logic             led_output_pin_o,
  output logic             led_output_pin_oe_o
);

  typedef struct packed {
    logic       wait_n;
    logic [7:0] rdata;
    logic [7:0] port7_output_data;
    logic [7:0] port7_pin_direction;
    logic [7:0] first_port_mode_reg;
    logic [7:0] fifth_port_mode_reg;
    logic [7:0] request_edge_select;
    logic [7:0] wakeup_edge_select_reg;
    logic [7:0] request_enable;
    logic [3:0] general_request_flags;
    logic [5:0] wakeup_flags;
    logic       nmi_pending;
    logic       mask;
    eiu_req_t   req;
    logic       led;
    logic       led_oe;
  } eiu_top_st_t;

  logic [1:0]          rst_sync_q;
  logic                rst_n;
  eiu_top_st_t         st_q;
  eiu_top_st_t         st_d;
  logic [NUM_PINS-1:0] pins;
  logic [NUM_PINS-1:0] rise_sel;
  logic [NUM_PINS-1:0] pulse;
  logic                busy;
  logic                take;
  eiu_src_t            take_src;

  // The release of reset is retimed; the assertion stays asynchronous.
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rst_sync_q <= RST_SYNC;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  assign pins     = {wakeup_pins_i, irq_pins_i, nmi_pin_i};
  assign rise_sel = {st_q.wakeup_edge_select_reg[5:0],
                     st_q.request_edge_select[3:0],
                     st_q.request_edge_select[NMI_EDGE_BIT]};

  eiu_edge u_edge (
    .ref_clk_i  (ref_clk_i),
    .rst_b_i    (rst_n),
    .pins_i     (pins),
    .rise_sel_i (rise_sel),
    .pulse_o    (pulse)
  );

  eiu_accept u_accept (
    .ref_clk_i  (ref_clk_i),
    .rst_b_i    (rst_n),
    .req_i      (st_q.req),
    .ccr_i      ({st_q.mask, cpu_ccr_i[MASK_BIT-1:0]}),
    .busy_o     (busy),
    .take_o     (take),
    .take_src_o (take_src),
    .insn_end_i (cpu_insn_end_i),
    .next_pc_i  (cpu_next_pc_i),
    .stack_o    (cpu_stack_o),
    .vector_o   (cpu_vector_o)
  );

  always_comb
  begin
    logic       acc;
    logic       wr;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [3:0] irq_set;
    logic [5:0] wake_set;
    logic [3:0] irq_clr;
    logic [5:0] wake_clr;
    logic [3:0] irq_live;
    logic       wake_live;
    acc       = 1'b0;
    wr        = 1'b0;
    wd        = 8'h00;
    rd        = 8'h00;
    irq_set   = 4'h0;
    wake_set  = 6'h00;
    irq_clr   = 4'h0;
    wake_clr  = 6'h00;
    irq_live  = 4'h0;
    wake_live = 1'b0;
    st_d      = st_q;

    // Bus: one wait cycle, then the request is taken at the next edge.
    acc        = avs_read_i || avs_write_i;
    st_d.wait_n = acc && !st_q.wait_n;
    wr         = avs_write_i && st_q.wait_n && avs_byteenable_i[0];
    wd         = avs_writedata_i[7:0];

    if (reg_hit(avs_address_i, IDX_PORT7_DATA))
    begin
      rd = st_q.port7_output_data;
    end
    else if (reg_hit(avs_address_i, IDX_PORT7_DIR))
    begin
      rd = st_q.port7_pin_direction;
    end
    else if (reg_hit(avs_address_i, IDX_PORT_MODE1))
    begin
      rd = st_q.first_port_mode_reg;
    end
    else if (reg_hit(avs_address_i, IDX_PORT_MODE5))
    begin
      rd = st_q.fifth_port_mode_reg;
    end
    else if (reg_hit(avs_address_i, IDX_CPU_MASK))
    begin
      rd = {st_q.mask, 7'h00};
    end
    else if (reg_hit(avs_address_i, IDX_EDGE_SEL))
    begin
      rd = st_q.request_edge_select;
    end
    else if (reg_hit(avs_address_i, IDX_WAKE_EDGE))
    begin
      rd = st_q.wakeup_edge_select_reg;
    end
    else if (reg_hit(avs_address_i, IDX_ENABLE))
    begin
      rd = st_q.request_enable;
    end
    else if (reg_hit(avs_address_i, IDX_FLAGS))
    begin
      rd = {4'h0, st_q.general_request_flags};
    end
    else if (reg_hit(avs_address_i, IDX_WAKE_FLAGS))
    begin
      rd = {2'h0, st_q.wakeup_flags};
    end
    if (avs_read_i && !st_q.wait_n)
    begin
      st_d.rdata = rd;
    end

    if (wr)
    begin
      if (reg_hit(avs_address_i, IDX_PORT7_DATA))
      begin
        st_d.port7_output_data = wd;
      end
      else if (reg_hit(avs_address_i, IDX_PORT7_DIR))
      begin
        st_d.port7_pin_direction = wd;
      end
      else if (reg_hit(avs_address_i, IDX_PORT_MODE1))
      begin
        st_d.first_port_mode_reg = wd;
      end
      else if (reg_hit(avs_address_i, IDX_PORT_MODE5))
      begin
        st_d.fifth_port_mode_reg = wd;
      end
      else if (reg_hit(avs_address_i, IDX_CPU_MASK))
      begin
        st_d.mask = wd[MASK_BIT];
      end
      else if (reg_hit(avs_address_i, IDX_EDGE_SEL))
      begin
        st_d.request_edge_select = wd;
      end
      else if (reg_hit(avs_address_i, IDX_WAKE_EDGE))
      begin
        st_d.wakeup_edge_select_reg = wd;
      end
      else if (reg_hit(avs_address_i, IDX_ENABLE))
      begin
        st_d.request_enable = wd;
      end
      else if (reg_hit(avs_address_i, IDX_FLAGS))
      begin
        irq_clr = ~wd[3:0];
      end
      else if (reg_hit(avs_address_i, IDX_WAKE_FLAGS))
      begin
        wake_clr = ~wd[5:0];
      end
    end

    irq_set  = pulse[PIN_IRQ_LO +: 4] & st_q.first_port_mode_reg[MODE1_IRQ_LO +: 4];
    wake_set = pulse[PIN_WAKE_LO +: 6] & st_q.fifth_port_mode_reg[5:0];
    st_d.general_request_flags = (st_q.general_request_flags & ~irq_clr) | irq_set;
    st_d.wakeup_flags          = (st_q.wakeup_flags & ~wake_clr) | wake_set;

    st_d.nmi_pending = (st_q.nmi_pending && !(take && take_src == SRC_NMI)) || pulse[PIN_NMI];

    if (take)
    begin
      st_d.mask = 1'b1;
    end

    irq_live  = st_q.general_request_flags & st_q.request_enable[3:0];
    wake_live = (|st_q.wakeup_flags) && st_q.request_enable[WAKE_EN_BIT];

    // Flags are updated with set winning over clear, so a flag cleared by a
    // write that meets a new edge is still seen and still taken.
    // coinciding request kept
    st_d.req = '{valid: 1'b0, src: SRC_NMI};
    if (st_q.nmi_pending)
    begin
      st_d.req = '{valid: 1'b1, src: SRC_NMI};
    end
    else if (!st_q.mask)
    begin
      if (irq_live[0])
      begin
        st_d.req = '{valid: 1'b1, src: SRC_IRQ0};
      end
      else if (irq_live[1])
      begin
        st_d.req = '{valid: 1'b1, src: SRC_IRQ0 + 3'h1};
      end
      else if (irq_live[2])
      begin
        st_d.req = '{valid: 1'b1, src: SRC_IRQ0 + 3'h2};
      end
      else if (irq_live[3])
      begin
        st_d.req = '{valid: 1'b1, src: SRC_IRQ0 + 3'h3};
      end
      else if (wake_live)
      begin
        st_d.req = '{valid: 1'b1, src: SRC_WAKE};
      end
    end
    // Nothing is forwarded while an acceptance runs; this avoids a
    // stale request being taken twice.
    if (busy || take)
    begin
      st_d.req.valid = 1'b0;
    end

    st_d.led    = st_q.port7_output_data[LED_BIT];
    st_d.led_oe = st_q.port7_pin_direction[LED_BIT];
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= '{mask: RST_MASK, default: '0};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign avs_waitrequest_o   = !st_q.wait_n;
  assign avs_readdata_o      = {24'h000000, st_q.rdata};
  assign cpu_req_o           = st_q.req;
  assign cpu_mask_o          = st_q.mask;
  assign led_output_pin_o    = st_q.led;
  assign led_output_pin_oe_o = st_q.led_oe;

endmodule // eiu_top

// *** dv/eiu_monitor.sv ***
// Checker of bus timing, CPU acceptance sequence and LED pin of the interrupt unit.
module eiu_monitor
  import eiu_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk_i,
  input wire logic        rst_b_i,
  // Bus
  input wire logic [17:0] avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  // CPU side
  input wire logic        cpu_insn_end_i,
  input wire logic [15:0] cpu_next_pc_i,
  input wire logic [7:0]  cpu_ccr_i,
  input wire eiu_req_t    cpu_req_o,
  input wire logic        cpu_mask_o,
  input wire eiu_stack_t  cpu_stack_o,
  input wire eiu_vec_t    cpu_vector_o,
  // LED pin
  input wire logic        led_output_pin_o,
  input wire logic        led_output_pin_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  logic wr_ok;
  logic wd_led;
  assign wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] && avs_address_i[1:0] == 2'h0;
  assign wd_led = avs_writedata_i[LED_BIT];
  sequence s_push;
    cpu_stack_o.we ##1 cpu_stack_o.we ##1 cpu_vector_o.load;
  endsequence
  property p_ack;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer timing wrong");
  property p_rdata;
    avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data upper bits not zero");
  // Read data is captured one edge before the answer, so it shows the mask of that edge.
  property p_mask_rd;
    avs_read_i && !avs_waitrequest_o && avs_address_i[17:2] == IDX_CPU_MASK
      |-> avs_readdata_o[7:0] == {$past(cpu_mask_o), 7'h00};
  endproperty
  a_mask_rd: assert property (p_mask_rd) else $error("mask read back wrong");
  property p_led;
    wr_ok && avs_address_i[17:2] == IDX_PORT7_DATA |-> ##2 led_output_pin_o == $past(wd_led, 2);
  endproperty
  a_led: assert property (p_led) else $error("LED level does not follow data bit");
  property p_oe;
    wr_ok && avs_address_i[17:2] == IDX_PORT7_DIR |-> ##2 led_output_pin_oe_o == $past(wd_led, 2);
  endproperty
  a_oe: assert property (p_oe) else $error("LED enable does not follow direction bit");
  property p_seq;
    $rose(cpu_stack_o.we) |-> s_push;
  endproperty
  a_seq: assert property (p_seq) else $error("stacking order wrong");
  property p_pc;
    $rose(cpu_stack_o.we) |-> $past(cpu_insn_end_i) && cpu_stack_o.data == $past(cpu_next_pc_i);
  endproperty
  a_pc: assert property (p_pc) else $error("stacked address wrong");
  property p_ccr;
    $rose(cpu_stack_o.we) |=> cpu_stack_o.data[15:8] == 8'h00 && cpu_stack_o.data[6:0] == cpu_ccr_i[6:0];
  endproperty
  a_ccr: assert property (p_ccr) else $error("stacked flags wrong");
  property p_mask;
    $rose(cpu_stack_o.we) |-> cpu_mask_o [*3];
  endproperty
  a_mask: assert property (p_mask) else $error("mask not set during acceptance");
  property p_nmi;
    $rose(cpu_req_o.valid) && cpu_mask_o |-> cpu_req_o.src == SRC_NMI;
  endproperty
  a_nmi: assert property (p_nmi) else $error("maskable request forwarded while masked");
  property p_vec;
    cpu_vector_o.load |-> cpu_vector_o.addr[0] == 1'b0 && cpu_vector_o.addr <= VEC_BASE + 16'ha;
  endproperty
  a_vec: assert property (p_vec) else $error("vector address out of table");
endmodule // eiu_monitor

// *** dv/eiu_cpu_model.sv ***
// CPU core model: instruction ends, next-instruction address and condition codes.
module eiu_cpu_model (
  // Clock and reset
  input  wire logic   ref_clk_i,
  input  wire logic   rst_b_i,
  // Pace: low ends an instruction every cycle, high every eighth cycle
  input  wire logic   slow_i,
  // Core signals
  output logic        insn_end_o,
  output logic [15:0] next_pc_o,
  output logic [7:0]  ccr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] gap_q;
  assign ccr_o = 8'h2a;
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      gap_q <= 3'h0;
      insn_end_o <= 1'b0;
      next_pc_o <= 16'h0100;
    end
    else
    begin
      insn_end_o <= !slow_i || gap_q == 3'h0;
      gap_q <= gap_q + 3'h1;
      if (insn_end_o)
        next_pc_o <= next_pc_o + 16'h2;
    end
  end
endmodule // eiu_cpu_model

// *** dv/tb.sv ***
// Self-checking bench for the external interrupt unit.
module tb
  import eiu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        nmi = 1'b0;
  logic [3:0]  irq = 4'hf;
  logic [5:0]  wkp = 6'h00;
  logic [17:0] adr = 18'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0]  be = 4'h1;
  logic        slow = 1'b0;
  logic [31:0] rdata;
  logic        waitreq, insn_end, mask, led, led_oe;
  logic [15:0] next_pc;
  logic [7:0]  ccr, val, exp_f;
  eiu_req_t    req;
  eiu_stack_t  stk;
  eiu_vec_t    vec;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  logic [15:0] rw_idx [5] = '{IDX_PORT7_DATA, IDX_PORT7_DIR, IDX_EDGE_SEL, IDX_ENABLE, IDX_WAKE_EDGE};
  logic [7:0]  rw_msk [5] = '{8'hff, 8'hff, 8'h8f, 8'h2f, 8'h3f};

  always #4 clk = ~clk;

  eiu_top DUT (
    .ref_clk_i(clk), .rst_b_i(rst_b), .nmi_pin_i(nmi), .irq_pins_i(irq), .wakeup_pins_i(wkp),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .cpu_insn_end_i(insn_end), .cpu_next_pc_i(next_pc), .cpu_ccr_i(ccr), .cpu_req_o(req),
    .cpu_mask_o(mask), .cpu_stack_o(stk), .cpu_vector_o(vec),
    .led_output_pin_o(led), .led_output_pin_oe_o(led_oe)
  );

  eiu_cpu_model u_cpu (
    .ref_clk_i(clk), .rst_b_i(rst_b), .slow_i(slow),
    .insn_end_o(insn_end), .next_pc_o(next_pc), .ccr_o(ccr)
  );

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Holds the request until waitrequest is sampled low, then idles one cycle.
  task automatic bus(input logic [15:0] idx, input logic w, input logic [7:0] d, input logic [3:0] b);
    adr <= {idx, 2'h0};
    rd <= !w;
    wr <= w;
    wd <= {24'h0, d};
    be <= b;
    do @(posedge clk); while (waitreq !== 1'b0);
    val = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr8(input logic [15:0] idx, input logic [7:0] d);
    bus(idx, 1'b1, d, 4'h1);
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp, input logic [7:0] m);
    bus(idx, 1'b0, 8'h00, 4'h1);
    check8(val & m, exp & m);
  endtask

  task automatic wait_vec(input logic [15:0] exp);
    int n;
    n = 0;
    while (vec.load !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    // The vector address holds its last value, so a missing load must fail here.
    check8({7'h0, vec.load}, 8'h01);
    check16(vec.addr, exp);
    check8({7'h0, mask}, 8'h01);
  endtask

  task automatic no_req(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n)
    begin
      @(posedge clk);
      seen = seen | (req.valid !== 1'b0);
    end
    check8({7'h0, seen}, 8'h00);
  endtask

  task automatic stop_test();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      num_errors++;
      stop_test();
    end
  end

  initial
  begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(IDX_FLAGS, 8'h00, 8'h0f);
    rd_chk(IDX_CPU_MASK, 8'h80, 8'h80);
    for (int i = 0; i < 5; i++)
    begin
      wr8(rw_idx[i], 8'hd5);
      rd_chk(rw_idx[i], 8'hd5, rw_msk[i]);
    end
    check8({6'h0, led, led_oe}, 8'h03);
    bus(IDX_PORT7_DATA, 1'b1, 8'h00, 4'h0);
    rd_chk(IDX_PORT7_DATA, 8'hd5, 8'hff);
    wr8(16'h1000, 8'hff);
    rd_chk(16'h1000, 8'h00, 8'hff);
    wr8(IDX_PORT7_DATA, 8'h00);
    repeat (2) @(posedge clk);
    check8({6'h0, led, led_oe}, 8'h01);
    $display("Test registers done");
    // Pin 0 on its falling edge, held while masked, taken once unmasked.
    wr8(IDX_EDGE_SEL, 8'h80);
    wr8(IDX_PORT_MODE1, 8'h10);
    wr8(IDX_ENABLE, 8'h01);
    wr8(IDX_FLAGS, 8'h00);
    irq[0] <= 1'b0;
    repeat (4) @(posedge clk);
    rd_chk(IDX_FLAGS, 8'h01, 8'h0f);
    no_req(8);
    wr8(IDX_CPU_MASK, 8'h00);
    wait_vec(VEC_BASE + 16'h2);
    rd_chk(IDX_CPU_MASK, 8'h80, 8'h80);
    irq[0] <= 1'b1;
    wr8(IDX_FLAGS, 8'h0f);
    rd_chk(IDX_FLAGS, 8'h01, 8'h0f);
    wr8(IDX_FLAGS, 8'h00);
    rd_chk(IDX_FLAGS, 8'h00, 8'h0f);
    $display("Test pin0 done");
    // Rising edges on pins 1 to 3, the first on pin 1 alone with its mode bit off.
    wr8(IDX_EDGE_SEL, 8'h8e);
    irq[1] <= 1'b0;
    repeat (2) @(posedge clk);
    irq[1] <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(IDX_FLAGS, 8'h00, 8'h0f);
    wr8(IDX_PORT_MODE1, 8'hf0);
    exp_f = 8'h00;
    for (int i = 1; i < 4; i++)
    begin
      irq[i] <= 1'b0;
      repeat (4) @(posedge clk);
      rd_chk(IDX_FLAGS, exp_f, 8'h0f);
      irq[i] <= 1'b1;
      repeat (4) @(posedge clk);
      exp_f[i] = 1'b1;
      rd_chk(IDX_FLAGS, exp_f, 8'h0f);
    end
    slow <= 1'b1;
    wr8(IDX_ENABLE, 8'h0c);
    wr8(IDX_CPU_MASK, 8'h00);
    wait_vec(VEC_BASE + 16'h6);
    wr8(IDX_FLAGS, 8'h0b);
    wr8(IDX_CPU_MASK, 8'h00);
    wait_vec(VEC_BASE + 16'h8);
    wr8(IDX_FLAGS, 8'h03);
    wr8(IDX_CPU_MASK, 8'h00);
    no_req(20);
    wr8(IDX_CPU_MASK, 8'h80);
    wr8(IDX_FLAGS, 8'h00);
    slow <= 1'b0;
    $display("Test priority done");
    // Wakeup pins: only pin 1 configured, group enable gates forwarding.
    wr8(IDX_WAKE_EDGE, 8'h3f);
    wr8(IDX_PORT_MODE5, 8'h02);
    wkp <= 6'h3f;
    repeat (4) @(posedge clk);
    rd_chk(IDX_WAKE_FLAGS, 8'h02, 8'h3f);
    wr8(IDX_CPU_MASK, 8'h00);
    no_req(12);
    wr8(IDX_ENABLE, 8'h20);
    wait_vec(VEC_BASE + 16'ha);
    wkp <= 6'h00;
    wr8(IDX_WAKE_FLAGS, 8'h00);
    repeat (4) @(posedge clk);
    rd_chk(IDX_WAKE_FLAGS, 8'h00, 8'h3f);
    $display("Test wakeup done");
    // Non-maskable pin on both edges while the mask is set.
    nmi <= 1'b1;
    wait_vec(VEC_BASE);
    wr8(IDX_EDGE_SEL, 8'h0e);
    nmi <= 1'b0;
    wait_vec(VEC_BASE);
    $display("Test non-maskable done");
    stop_test();
  end
endmodule // tb

bind eiu_top eiu_monitor u_mon (
  .ref_clk_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
  .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .cpu_insn_end_i, .cpu_next_pc_i,
  .cpu_ccr_i, .cpu_req_o, .cpu_mask_o, .cpu_stack_o, .cpu_vector_o,
  .led_output_pin_o, .led_output_pin_oe_o
);
